// ===== irqp_pkg.sv
// Purpose: shared constants, carriers and helpers of the irq resolver
// Assumes: 32-bit AXI4-Lite register bus, one clock domain
// Notes:   arbiter request slots 0 and 5 never rotate
`default_nettype none

package irqp_pkg;

    localparam int NSRC = 32;
    localparam int NGRP = 6;
    localparam int NREQ = 6;

    // register byte addresses
    localparam logic [31:0] ADDR_PRIO = 32'h4a00_000c;
    localparam logic [31:0] ADDR_PEND = 32'h4a00_0010;
    localparam logic [31:0] ADDR_INDEX = 32'h4a00_0014;

    // reset values and writable bits
    localparam logic [31:0] PRIO_RESET = 32'h0000_007f;
    localparam logic [31:0] PRIO_WMASK = 32'h001f_ffff;
    localparam logic [31:0] PEND_RESET = 32'h0000_0000;
    localparam logic [4:0] INDEX_RESET = 5'h00;

    // priority register field layout
    localparam int ROT_LSB = 0;
    localparam int SEL_LSB = 7;
    localparam int SEL_W = 2;
    localparam int TOP_ARB = 6;

    // first source index of request slot 0 of each group, modulo 32
    localparam logic [NGRP-1:0][4:0] GRP_BASE =
        {5'h1b, 5'h16, 5'h10, 5'h0a, 5'h04, 5'h1f};
    // groups that only use request slots 1 to 4
    localparam logic [NGRP-1:0] GRP_FOUR = 6'h21;
    localparam logic [2:0] REQ_FIRST = 3'h0;
    localparam logic [2:0] REQ_LAST = 3'h5;
    localparam logic [2:0] REQ_ONE = 3'h1;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // one write command from the bus side
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } irqp_wr_s;

    // one read answer toward the bus side
    typedef struct packed {
        logic [31:0] data;
        logic err;
    } irqp_rd_s;

    // request slot served at priority position pos under order select sel
    function automatic logic [2:0] irqp_order_req(input logic [2:0] pos,
                                                  input logic [1:0] sel);
        logic [1:0] k;
        k = 2'(pos - REQ_ONE) + sel;
        if (pos == REQ_FIRST || pos == REQ_LAST) begin
            return pos;
        end
        return {1'b0, k} + REQ_ONE;
    endfunction : irqp_order_req

    // order select that moves the granted slot to the back of the ring
    function automatic logic [1:0] irqp_next_sel(input logic [2:0] req,
                                                 input logic [1:0] cur);
        if (req == REQ_FIRST || req == REQ_LAST) begin
            return cur;
        end
        return req[1:0];
    endfunction : irqp_next_sel

    // byte strobes widened to a bit mask
    function automatic logic [31:0] irqp_strb_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : irqp_strb_mask

endpackage : irqp_pkg

`default_nettype wire

// ===== irqp_arbiter.sv
// Purpose: six-slot fixed-ends priority arbiter, purely combinational
// Assumes: slot 0 always first, slot 5 always last
// Notes:   slots 1 to 4 follow the ring picked by sel
`default_nettype none

module irqp_arbiter
    import irqp_pkg::*;
(
    input wire logic [NREQ-1:0] req, // request per slot
    input wire logic [1:0] sel,      // order select
    output logic any,                // some slot requests
    output logic [2:0] grant         // winning slot
);

    logic [2:0] slot;

    // walk positions from lowest to highest priority, last hit wins
    always_comb begin
        slot = REQ_FIRST;
        any = 1'b0;
        grant = REQ_FIRST;
        for (int p = NREQ - 1; p >= 0; p--) begin
            slot = irqp_order_req(3'(p), sel);
            if (req[slot]) begin
                any = 1'b1;
                grant = slot;
            end
        end
    end

endmodule : irqp_arbiter

`default_nettype wire

// ===== irqp_axil_slave.sv
// Purpose: AXI4-Lite handshake front end for the resolver registers
// Assumes: one write and one read outstanding at most
// Notes:   address and data are taken in either order
`default_nettype none

module irqp_axil_slave
    import irqp_pkg::*;
(
    input wire logic aclk,            // system clock
    input wire logic aresetn,         // sync reset, low
    input wire logic [31:0] awaddr,   // write address
    input wire logic awvalid,         // write address valid
    output logic awready,             // write address ready
    input wire logic [31:0] wdata,    // write data
    input wire logic [3:0] wstrb,     // write strobes
    input wire logic wvalid,          // write data valid
    output logic wready,              // write data ready
    output logic [1:0] bresp,         // write response
    output logic bvalid,              // write response valid
    input wire logic bready,          // write response ready
    input wire logic [31:0] araddr,   // read address
    input wire logic arvalid,         // read address valid
    output logic arready,             // read address ready
    output logic [31:0] rdata,        // read data
    output logic [1:0] rresp,         // read response
    output logic rvalid,              // read data valid
    input wire logic rready,          // read data ready
    output irqp_wr_s wr,              // held write command
    output logic wr_go,               // write executes this cycle
    input wire logic wr_err,          // write target is not writable
    output logic rd_go,               // read taken this cycle
    input wire irqp_rd_s rd           // answer for araddr
);

    logic aw_held;
    logic w_held;
    logic [31:0] held_addr;
    logic [31:0] held_data;
    logic [3:0] held_strb;

    // one process per channel, merged into the command carrier
    assign wr = '{addr: held_addr, data: held_data, strb: held_strb};

    // a write runs once both halves are held and no response waits
    assign wr_go = aw_held && w_held && !bvalid;
    assign rd_go = arvalid && arready;

    // write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            awready <= 1'b0;
            held_addr <= '0;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            awready <= 1'b0;
            held_addr <= awaddr;
        end else begin
            if (wr_go) begin
                aw_held <= 1'b0;
            end
            awready <= !aw_held && !bvalid;
        end
    end

    // write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            wready <= 1'b0;
            held_data <= '0;
            held_strb <= '0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            wready <= 1'b0;
            held_data <= wdata;
            held_strb <= wstrb;
        end else begin
            if (wr_go) begin
                w_held <= 1'b0;
            end
            wready <= !w_held && !bvalid;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read channel: data is sampled at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (rd_go) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd.data;
            rresp <= rd.err ? RESP_SLVERR : RESP_OKAY;
        end else begin
            if (rready) begin
                rvalid <= 1'b0;
            end
            arready <= !rvalid;
        end
    end

endmodule : irqp_axil_slave

`default_nettype wire

// ===== irqp_resolver.sv
// Purpose: priority resolution and winner reporting for 32 irq sources
// Assumes: pending, mask and mode bits come from same-clock logic
// Notes:   registers reached over AXI4-Lite
//
// Notes on behaviour
// - seven rotate bits, set means rotate, reset ones
// - arbiters 0-5 take six order selects
// - arbiter 6 order select at bits 20:19
// - arbiters 0 and 5 serve requests 1-4
// - one-hot winner register drives normal irq
// - only unmasked waiting requests may win
// - writing one clears, zero leaves bit alone
// - winner register resets to zero
// - fast-mode sources never enter winner register
// - index register holds winner bit position
// - index clears once both pending bits clear
// - fast-mode sources leave index untouched
// - masked sources still pend but are not served
// - mode bit one means fast, one at most
`default_nettype none

module irqp_resolver
    import irqp_pkg::*;
(
    input wire logic aclk,                      // system clock
    input wire logic aresetn,                   // sync reset, low
    input wire logic [31:0] s_axi_awaddr,       // write address
    input wire logic s_axi_awvalid,             // write address valid
    output logic s_axi_awready,                 // write address ready
    input wire logic [31:0] s_axi_wdata,        // write data
    input wire logic [3:0] s_axi_wstrb,         // write strobes
    input wire logic s_axi_wvalid,              // write data valid
    output logic s_axi_wready,                  // write data ready
    output logic [1:0] s_axi_bresp,             // write response
    output logic s_axi_bvalid,                  // write response valid
    input wire logic s_axi_bready,              // write response ready
    input wire logic [31:0] s_axi_araddr,       // read address
    input wire logic s_axi_arvalid,             // read address valid
    output logic s_axi_arready,                 // read address ready
    output logic [31:0] s_axi_rdata,            // read data
    output logic [1:0] s_axi_rresp,             // read response
    output logic s_axi_rvalid,                  // read data valid
    input wire logic s_axi_rready,              // read data ready
    input wire logic [NSRC-1:0] source_pending_bits,   // waiting sources
    input wire logic [NSRC-1:0] source_mask_bits,      // 1 = masked
    input wire logic [NSRC-1:0] fast_mode_select_bits, // 1 = fast mode
    output logic irq_req                        // normal irq to core
);

    logic [31:0] prio;
    logic [NSRC-1:0] pend;
    logic [4:0] index;
    logic [31:0] next_prio;
    logic [NSRC-1:0] next_pend;
    logic [4:0] next_index;

    irqp_wr_s wr;
    irqp_rd_s rd;
    logic wr_go;
    logic wr_err;
    logic rd_go;
    logic wr_prio;
    logic wr_pend;
    logic [31:0] wr_bits;

    logic [NSRC-1:0] eligible;
    logic [NGRP-1:0][NREQ-1:0] grp_req;
    logic [NGRP-1:0] grp_any;
    logic [NGRP-1:0][2:0] grp_grant;
    logic top_any;
    logic [2:0] top_grant;
    logic [2:0] win_slot;
    logic [4:0] win_idx;
    logic latch;

    // bus front end
    irqp_axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr(wr),
        .wr_go(wr_go),
        .wr_err(wr_err),
        .rd_go(rd_go),
        .rd(rd)
    );

    // write decode; the index register is read-only
    assign wr_prio = wr_go && (wr.addr == ADDR_PRIO);
    assign wr_pend = wr_go && (wr.addr == ADDR_PEND);
    assign wr_err = (wr.addr != ADDR_PRIO) && (wr.addr != ADDR_PEND);
    assign wr_bits = wr.data & irqp_strb_mask(wr.strb);

    // read decode, unmapped addresses answer an error with zero data
    always_comb begin
        rd.data = '0;
        rd.err = 1'b0;
        case (s_axi_araddr)
            ADDR_PRIO: rd.data = prio & PRIO_WMASK;
            ADDR_PEND: rd.data = pend;
            ADDR_INDEX: rd.data = {27'h000_0000, index};
            default: rd.err = 1'b1;
        endcase
    end

    // masked, fast-mode and idle sources cannot compete
    assign eligible = source_pending_bits & ~source_mask_bits
                    & ~fast_mode_select_bits;

    // spread sources over the six groups, slot r of group g
    always_comb begin
        for (int g = 0; g < NGRP; g++) begin
            for (int r = 0; r < NREQ; r++) begin
                if (GRP_FOUR[g] && (3'(r) == REQ_FIRST
                                    || 3'(r) == REQ_LAST)) begin
                    grp_req[g][r] = 1'b0;
                end else begin
                    grp_req[g][r] = eligible[5'(GRP_BASE[g] + 5'(r))];
                end
            end
        end
    end

    // group arbiters 0 to 5, each steered by its own order select
    for (genvar g = 0; g < NGRP; g++) begin : g_grp
        irqp_arbiter u_arb (
            .req(grp_req[g]),
            .sel(prio[SEL_LSB + SEL_W * g +: SEL_W]),
            .any(grp_any[g]),
            .grant(grp_grant[g])
        );
    end

    // final arbiter picks among the group winners
    irqp_arbiter u_top (
        .req(grp_any),
        .sel(prio[SEL_LSB + SEL_W * TOP_ARB +: SEL_W]),
        .any(top_any),
        .grant(top_grant)
    );

    // source number of the overall winner
    always_comb begin
        win_slot = grp_grant[0];
        for (int g = 1; g < NGRP; g++) begin
            if (top_grant == 3'(g)) begin
                win_slot = grp_grant[g];
            end
        end
        win_idx = 5'(GRP_BASE[top_grant] + 5'(win_slot));
    end

    // a new winner is latched only while no winner is held
    assign latch = (pend == PEND_RESET) && top_any;

    // priority register: rotation after a grant, bus write on top
    always_comb begin
        next_prio = prio;
        if (latch) begin
            for (int g = 0; g < NGRP; g++) begin
                if (top_grant == 3'(g) && prio[ROT_LSB + g]) begin
                    next_prio[SEL_LSB + SEL_W * g +: SEL_W] =
                        irqp_next_sel(win_slot,
                            prio[SEL_LSB + SEL_W * g +: SEL_W]);
                end
            end
            if (prio[ROT_LSB + TOP_ARB]) begin
                next_prio[SEL_LSB + SEL_W * TOP_ARB +: SEL_W] =
                    irqp_next_sel(top_grant,
                        prio[SEL_LSB + SEL_W * TOP_ARB +: SEL_W]);
            end
        end
        if (wr_prio) begin
            next_prio = ((next_prio & ~irqp_strb_mask(wr.strb))
                      | wr_bits) & PRIO_WMASK;
        end
    end

    // priority control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio <= PRIO_RESET;
        end else begin
            prio <= next_prio;
        end
    end

    // winner register: write-one-to-clear, a new winner sets one bit
    always_comb begin
        next_pend = pend;
        if (wr_pend) begin
            next_pend = pend & ~wr_bits;
        end
        if (latch) begin
            next_pend = NSRC'(1) << win_idx;
        end
    end

    // winner register and the irq line it drives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend <= PEND_RESET;
            irq_req <= 1'b0;
        end else begin
            pend <= next_pend;
            irq_req <= |next_pend;
        end
    end

    // index follows each latch, drops once both pending bits are gone
    always_comb begin
        next_index = index;
        if (latch) begin
            next_index = win_idx;
        end else if (pend == PEND_RESET
                     && !source_pending_bits[index]) begin
            next_index = INDEX_RESET;
        end
    end

    // winner index register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            index <= INDEX_RESET;
        end else begin
            index <= next_index;
        end
    end

endmodule : irqp_resolver

`default_nettype wire

// ===== irqp_resolver_assertions.sv
// Purpose: port checks for the irq resolver
// Assumes: one clock, sync active-low reset
// Notes:   attached by bind from the bench
`default_nettype none
module irqp_resolver_assertions
    import irqp_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, low
    input wire logic [31:0] s_axi_awaddr, // aw addr
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_bvalid, // b valid
    input wire logic [31:0] s_axi_araddr, // ar addr
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic s_axi_rvalid, // r valid
    input wire logic [NSRC-1:0] source_pending_bits, // pending
    input wire logic [NSRC-1:0] source_mask_bits, // mask
    input wire logic [NSRC-1:0] fast_mode_select_bits, // fast
    input wire logic irq_req // irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NSRC-1:0] elig;
    logic wr_hs;
    logic rd_hs;
    // eligible sources and bus handshakes
    assign elig = source_pending_bits & ~source_mask_bits
                  & ~fast_mode_select_bits;
    assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                   && s_axi_wready;
    assign rd_hs = s_axi_arvalid && s_axi_arready;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_irq_cause;
        $rose(irq_req) |-> $past(|elig);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq raised with no eligible source");
    property p_irq_latch;
        !irq_req && (|elig) |=> irq_req;
    endproperty
    a_irq_latch: assert property (p_irq_latch)
        else $error("eligible source not latched");
    property p_irq_quiet;
        !irq_req && elig == '0 |=> !irq_req;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("irq raised by masked or fast source");
    property p_irq_clear;
        $fell(irq_req) |-> $rose(s_axi_bvalid);
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("irq dropped without a write");
    property p_wr_lat;
        wr_hs |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat)
        else $error("write answer late or early");
    property p_idx_ro;
        wr_hs && s_axi_awaddr == ADDR_INDEX |-> ##2 s_axi_bresp == RESP_SLVERR;
    endproperty
    a_idx_ro: assert property (p_idx_ro)
        else $error("index write not refused");
    property p_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("write taken while answer pending");
    property p_pend_read;
        rd_hs && s_axi_araddr == ADDR_PEND |=>
            $onehot0(s_axi_rdata) && ((|s_axi_rdata) == $past(irq_req));
    endproperty
    a_pend_read: assert property (p_pend_read)
        else $error("winner register not one-hot or off irq");
    property p_idx_read;
        rd_hs && s_axi_araddr == ADDR_INDEX |=>
            s_axi_rvalid && s_axi_rdata[31:5] == 27'h0;
    endproperty
    a_idx_read: assert property (p_idx_read)
        else $error("index out of range");
    c_latch: cover property ($rose(irq_req));
    c_clear: cover property (wr_hs && s_axi_awaddr == ADDR_PEND);
    c_index: cover property (rd_hs && s_axi_araddr == ADDR_INDEX);
endmodule : irqp_resolver_assertions
`default_nettype wire

// ===== irqp_source_model.sv
// Purpose: source pending bits in front of the resolver
// Assumes: bench pulses raise and drop for one cycle
// Notes:   a masked source still pends
`default_nettype none
module irqp_source_model
    import irqp_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, low
    input wire logic [NSRC-1:0] raise_bits, // set
    input wire logic [NSRC-1:0] drop_bits, // clear
    output logic [NSRC-1:0] source_pending_bits // pending
);
    timeunit 1ns;
    timeprecision 1ps;
    // set on request, cleared by service
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_pending_bits <= '0;
        end else begin
            source_pending_bits <= (source_pending_bits & ~drop_bits)
                                   | raise_bits;
        end
    end
endmodule : irqp_source_model
`default_nettype wire

// ===== irq_priority_pending_resolver_bench.sv
// Purpose: self-checking bench of the irq resolver
// Assumes: AXI4-Lite master tasks, 125 MHz clock
// Notes:   expected winners follow the group and slot map
`default_nettype none
module irq_priority_pending_resolver_bench
    import irqp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq_req;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [NSRC-1:0] source_mask_bits = '0, fast_mode_select_bits = '0;
    logic [NSRC-1:0] raise_bits = '0, drop_bits = '0, source_pending_bits;
    int fail_count = 0;
    int checks_done = 0;
    // clock
    always #4 aclk = ~aclk;
    irqp_source_model i_src (.aclk, .aresetn, .raise_bits, .drop_bits,
        .source_pending_bits);
    irqp_resolver i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .source_pending_bits,
        .source_mask_bits, .fast_mode_select_bits, .irq_req);
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // write: address and data together, held until taken
    task automatic wrc(input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 64);
        s_axi_bready <= 1'b0;
        chk({31'h0, s_axi_bvalid}, 32'h1, "write answer");
        chk({30'h0, s_axi_bresp}, {30'h0, er}, "write resp");
        @(posedge aclk);
    endtask : wrc
    // read and compare data and response
    task automatic rdc(input logic [31:0] a, input logic [31:0] e,
                       input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 64);
        s_axi_rready <= 1'b0;
        chk({31'h0, s_axi_rvalid}, 32'h1, "read answer");
        chk(s_axi_rdata, e, "read data");
        chk({30'h0, s_axi_rresp}, {30'h0, er}, "read resp");
        @(posedge aclk);
    endtask : rdc
    task automatic raise(input logic [31:0] m);
        raise_bits <= m;
        @(posedge aclk);
        raise_bits <= '0;
        @(posedge aclk);
    endtask : raise
    // service routine: check winner, drop source, clear winner
    task automatic serve(input int idx);
        logic [31:0] e;
        int n;
        e = 32'h1 << idx;
        n = 0;
        while (irq_req !== 1'b1 && n < 16) begin
            @(posedge aclk);
            n++;
        end
        chk({31'h0, irq_req}, 32'h1, "irq up");
        rdc(ADDR_PEND, e, RESP_OKAY);
        rdc(ADDR_INDEX, 32'(idx), RESP_OKAY);
        drop_bits <= '1;
        @(posedge aclk);
        drop_bits <= '0;
        @(posedge aclk);
        wrc(ADDR_PEND, '1, ~(4'h1 << (idx / 8)), RESP_OKAY);
        rdc(ADDR_PEND, e, RESP_OKAY);
        wrc(ADDR_PEND, e, 4'hf, RESP_OKAY);
        rdc(ADDR_PEND, 32'h0, RESP_OKAY);
        rdc(ADDR_INDEX, 32'h0, RESP_OKAY);
        chk({31'h0, irq_req}, 32'h0, "irq down");
    endtask : serve
    task automatic test_reset;
        rdc(ADDR_PRIO, PRIO_RESET, RESP_OKAY);
        rdc(ADDR_PEND, 32'h0, RESP_OKAY);
        rdc(ADDR_INDEX, 32'h0, RESP_OKAY);
        rdc(32'h4a00_0020, 32'h0, RESP_SLVERR);
        wrc(ADDR_INDEX, 32'h0000_0005, 4'hf, RESP_SLVERR);
        rdc(ADDR_INDEX, 32'h0, RESP_OKAY);
        $display("test reset done");
    endtask : test_reset
    // fixed orders: every select code of arbiter 1, then group order
    task automatic test_order;
        logic [31:0] tp [6];
        logic [31:0] ts [6];
        int te [6];
        tp = '{32'h0, 32'h0000_0200, 32'h0000_0400, 32'h0000_0600, 32'h0,
               32'h0};
        ts = '{32'h0000_01e0, 32'h0000_01e0, 32'h0000_01e0, 32'h0000_01e0,
               32'h0000_0016, 32'h8000_0010};
        te = '{5, 6, 7, 8, 1, 4};
        for (int i = 0; i < 6; i++) begin
            wrc(ADDR_PRIO, tp[i], 4'hf, RESP_OKAY);
            rdc(ADDR_PRIO, tp[i], RESP_OKAY);
            raise(ts[i]);
            serve(te[i]);
        end
        $display("test order done");
    endtask : test_order
    task automatic test_rotate;
        wrc(ADDR_PRIO, PRIO_RESET, 4'hf, RESP_OKAY);
        raise(32'h0000_0060);
        serve(5);
        rdc(ADDR_PRIO, 32'h0008_027f, RESP_OKAY);
        raise(32'h0000_0060);
        serve(6);
        rdc(ADDR_PRIO, 32'h0008_047f, RESP_OKAY);
        $display("test rotate done");
    endtask : test_rotate
    task automatic test_mask_fast;
        source_mask_bits <= 32'h0000_0080;
        fast_mode_select_bits <= 32'h0000_0100;
        raise(32'h0000_0180);
        repeat (8) @(posedge aclk);
        chk({31'h0, irq_req}, 32'h0, "irq held off");
        rdc(ADDR_PEND, 32'h0, RESP_OKAY);
        rdc(ADDR_INDEX, 32'h0, RESP_OKAY);
        source_mask_bits <= '0;
        serve(7);
        fast_mode_select_bits <= '0;
        $display("test mask and fast done");
    endtask : test_mask_fast
    // main sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset();
        test_order();
        test_rotate();
        test_mask_fast();
        complete_run();
    end
    // watchdog
    initial begin
        #100_000;
        fail_count++;
        complete_run();
    end
endmodule : irq_priority_pending_resolver_bench
bind irqp_resolver irqp_resolver_assertions i_chk (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .source_pending_bits, .source_mask_bits, .fast_mode_select_bits,
    .irq_req);
`default_nettype wire
